// ### verilog/scec_pkg.sv
// Package for the shared cache event counter unit.
// Assumes a 32-bit word register port; the 44-bit counters and 48-bit clocktick are split into low/high words.
package scec_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int NUM_SLICES = 4;
  localparam int CTRS_PER_UNIT = 2;
  localparam int NUM_UNITS = NUM_SLICES + 1;
  localparam int NUM_CTRS = NUM_UNITS * CTRS_PER_UNIT;
  localparam int GP_WIDTH = 44;
  localparam int FIX_WIDTH = 48;
  localparam int EVT_WIDTH = 5;
  localparam int ADDR_WIDTH = 8;

  // ****************************************
  // Event selector field positions
  // ****************************************
  localparam int SEL_CODE_LO = 0;
  localparam int SEL_UNIT_MASK_FIELD_LO = 8;
  localparam int SEL_EDGE_BIT = 18;
  localparam int SEL_OVF_FWD_BIT = 20;
  localparam int SEL_EN_BIT = 22;
  localparam int SEL_NEG_BIT = 23;
  localparam int SEL_THR_LO = 24;
  localparam int SEL_THR_HI = 28;
  localparam logic [31:0] SEL_WR_MASK = 32'h1FD4FFFF;

  // ****************************************
  // Global control field positions
  // ****************************************
  localparam int GCTL_CORE_HI = 3;
  localparam int GCTL_EN_BIT = 29;
  localparam int GCTL_WAKE_BIT = 30;
  localparam int GCTL_FREEZE_BIT = 31;
  localparam logic [31:0] GCTL_WR_MASK = 32'hE000000F;
  localparam logic [31:0] GCTL_RESET = 32'h00000000;
  localparam logic [31:0] SEL_RESET = 32'h00000000;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_GCTL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_FIX_LO = 8'h0C;
  localparam logic [7:0] ADDR_FIX_HI = 8'h10;
  localparam logic [7:0] ADDR_SLICE_EN = 8'h14;
  localparam logic [7:0] ADDR_SEL_BASE = 8'h40;
  localparam logic [7:0] ADDR_CTR_BASE = 8'h80;
  localparam int CTR_STRIDE = 8;

  // ****************************************
  // Wake sequencing
  // ****************************************
  localparam int WAKE_TIME_NS = 8;
  localparam int CLK_PERIOD_NS = 4;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum {ST_IDLE, ST_WAKE, ST_IRQ} scec_state_t;

  // Register port request carrier.
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } scec_req_t;

  // Per-core delivery outputs.
  typedef struct packed {
    logic [NUM_SLICES-1:0] wake;
    logic [NUM_SLICES-1:0] performance_monitor_interrupt;
  } scec_core_t;
endpackage : scec_pkg

// ### verilog/scec_top.sv
// Shared cache event counter unit: slice and scheduler counters, clocktick counter, control.
// Assumes event values arrive synchronous to i_ref_clk, one value per counter per cycle.
`timescale 1ns/100ps
module scec_top (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Register port.
  input wire scec_pkg::scec_req_t i_req,
  output logic [31:0] o_rdata,
  // Event inputs: one value per counter, unit order slices then scheduler.
  input wire logic [scec_pkg::NUM_CTRS*scec_pkg::EVT_WIDTH-1:0] i_evt,
  // Core delivery.
  output scec_pkg::scec_core_t o_core,
  output logic o_irq
);
  import scec_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [31:0] gctl_r;
  logic [31:0] sel_r [NUM_CTRS];
  logic [GP_WIDTH-1:0] ctr_r [NUM_CTRS];
  logic [EVT_WIDTH-1:0] evt_r [NUM_CTRS];
  logic [NUM_CTRS-1:0] cond_prev_r;
  logic [FIX_WIDTH-1:0] fix_r;
  logic [NUM_SLICES-1:0] slice_en_r;
  logic [NUM_CTRS-1:0] sts_r;
  logic [NUM_CTRS-1:0] msk_r;
  logic [NUM_CTRS-1:0] ovf;
  logic [NUM_CTRS-1:0] cond;
  logic [GP_WIDTH-1:0] inc [NUM_CTRS];
  logic [NUM_CTRS-1:0] run;
  logic fwd_ovf;
  logic pending_r;
  scec_state_t state_r;
  logic [3:0] wait_r;
  logic [NUM_SLICES-1:0] tgt_r;
  logic glob_en;
  logic [31:0] rdata_nxt;
  logic [31:0] gctl_nxt;
  logic [NUM_CTRS-1:0] sts_clr;

  assign glob_en = gctl_r[GCTL_EN_BIT];

  // ****************************************
  // Per-counter event path
  // ****************************************
  // Event codes and unit masks are held for software; the event source is already selected
  // upstream, so the selector code only travels with the counter, never gating it here.
  always_comb begin
    for (int k = 0; k < NUM_CTRS; k++) begin
      logic [EVT_WIDTH-1:0] raw;
      logic [EVT_WIDTH-1:0] val;
      logic [EVT_WIDTH-1:0] thr;
      logic hit;
      raw = evt_r[k];
      thr = sel_r[k][SEL_THR_HI:SEL_THR_LO];
      // Negation counts the complement of the event value.
      val = sel_r[k][SEL_NEG_BIT] ? ~raw : raw;
      // Threshold zero passes the value straight; otherwise the condition is val >= thr.
      hit = (thr == 5'h00) ? (val != 5'h00) : (val >= thr);
      cond[k] = hit;
      if (sel_r[k][SEL_EDGE_BIT]) begin
        inc[k] = {{(GP_WIDTH-1){1'b0}}, hit & ~cond_prev_r[k]};
      end else if (thr != 5'h00) begin
        inc[k] = {{(GP_WIDTH-1){1'b0}}, hit};
      end else begin
        inc[k] = {{(GP_WIDTH-EVT_WIDTH){1'b0}}, val};
      end
      // Slices need their box enable as well as the global one; scheduler only global.
      if (k < NUM_SLICES*CTRS_PER_UNIT) begin
        run[k] = glob_en & sel_r[k][SEL_EN_BIT] & slice_en_r[k/CTRS_PER_UNIT];
      end else begin
        run[k] = glob_en & sel_r[k][SEL_EN_BIT];
      end
      ovf[k] = run[k] & (({1'b0, ctr_r[k]} + {1'b0, inc[k]}) > {1'b0, {GP_WIDTH{1'b1}}});
    end
  end

  // Forwarded overflows feed the global logic only when the selector allows it.
  always_comb begin
    fwd_ovf = 1'b0;
    for (int k = 0; k < NUM_CTRS; k++) begin
      fwd_ovf = fwd_ovf | (ovf[k] & sel_r[k][SEL_OVF_FWD_BIT]);
    end
  end

  // Event registers and edge history.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < NUM_CTRS; k++) begin
        evt_r[k] <= 5'h00;
      end
      cond_prev_r <= '0;
    end else begin
      for (int k = 0; k < NUM_CTRS; k++) begin
        evt_r[k] <= i_evt[k*EVT_WIDTH +: EVT_WIDTH];
      end
      cond_prev_r <= cond;
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  // Slice counters occupy units 0..3, scheduler counters unit 4. Wrap is natural.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < NUM_CTRS; k++) begin
        ctr_r[k] <= '0;
      end
    end else begin
      for (int k = 0; k < NUM_CTRS; k++) begin
        if (i_req.wr && i_req.addr == ADDR_CTR_BASE + 8'(k*CTR_STRIDE)) begin
          ctr_r[k][31:0] <= i_req.wdata;
        end else if (i_req.wr && i_req.addr == ADDR_CTR_BASE + 8'(k*CTR_STRIDE + 4)) begin
          ctr_r[k][GP_WIDTH-1:32] <= i_req.wdata[GP_WIDTH-33:0];
        end else if (run[k]) begin
          ctr_r[k] <= ctr_r[k] + inc[k];
        end
      end
    end
  end

  // Clocktick counter: fixed function, only the global enable gates it.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fix_r <= '0;
    end else if (i_req.wr && i_req.addr == ADDR_FIX_LO) begin
      fix_r[31:0] <= i_req.wdata;
    end else if (i_req.wr && i_req.addr == ADDR_FIX_HI) begin
      fix_r[FIX_WIDTH-1:32] <= i_req.wdata[FIX_WIDTH-33:0];
    end else if (glob_en) begin
      fix_r <= fix_r + 48'h000000000001;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Freeze clears the enable; it wins over a same-cycle software write so an overflow
  // never slips through unfrozen.
  always_comb begin
    gctl_nxt = gctl_r;
    if (i_req.wr && i_req.addr == ADDR_GCTL) begin
      gctl_nxt = i_req.wdata & GCTL_WR_MASK;
    end
    if (gctl_r[GCTL_FREEZE_BIT] && fwd_ovf) begin
      gctl_nxt[GCTL_EN_BIT] = 1'b0;
    end
  end

  // Global control register.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gctl_r <= GCTL_RESET;
    end else begin
      gctl_r <= gctl_nxt;
    end
  end

  // Selector and box-enable writes.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < NUM_CTRS; k++) begin
        sel_r[k] <= SEL_RESET;
      end
      slice_en_r <= '0;
    end else begin
      for (int k = 0; k < NUM_CTRS; k++) begin
        if (i_req.wr && i_req.addr == ADDR_SEL_BASE + 8'(k*4)) begin
          sel_r[k] <= i_req.wdata & SEL_WR_MASK;
        end
      end
      if (i_req.wr && i_req.addr == ADDR_SLICE_EN) begin
        slice_en_r <= i_req.wdata[NUM_SLICES-1:0];
      end
    end
  end

  // Write-one-to-clear mask for the status word.
  assign sts_clr = (i_req.wr && i_req.addr == ADDR_STATUS) ?
    i_req.wdata[NUM_CTRS-1:0] : '0;

  // Sticky overflow status, write one to clear; a new overflow beats the clear.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sts_r <= '0;
      msk_r <= '0;
    end else begin
      sts_r <= (sts_r & ~sts_clr) | ovf;
      if (i_req.wr && i_req.addr == ADDR_MASK) begin
        msk_r <= i_req.wdata[NUM_CTRS-1:0];
      end
    end
  end

  // Local interrupt line.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(sts_r & msk_r);
    end
  end

  // ****************************************
  // Core interrupt delivery
  // ****************************************
  // An overflow arriving during delivery sets the one pending flag and is served next; several arriving then collapse into one delivery.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= ST_IDLE;
      pending_r <= 1'b0;
      wait_r <= 4'h0;
      tgt_r <= '0;
      o_core <= '0;
    end else begin
      o_core <= '0;
      unique case (state_r)
        ST_IDLE: begin
          if ((fwd_ovf || pending_r) && gctl_r[GCTL_CORE_HI:0] != 4'h0) begin
            pending_r <= 1'b0;
            tgt_r <= gctl_r[GCTL_CORE_HI:0];
            if (gctl_r[GCTL_WAKE_BIT]) begin
              state_r <= ST_WAKE;
              wait_r <= 4'(WAKE_CYCLES);
              o_core.wake <= gctl_r[GCTL_CORE_HI:0];
            end else begin
              state_r <= ST_IRQ;
            end
          end
        end
        ST_WAKE: begin
          // Wake is held until the wait ends so halted cores see it before the interrupt.
          if (fwd_ovf) pending_r <= 1'b1;
          o_core.wake <= tgt_r;
          if (wait_r <= 4'h1) begin
            state_r <= ST_IRQ;
          end else begin
            wait_r <= wait_r - 4'h1;
          end
        end
        ST_IRQ: begin
          if (fwd_ovf) pending_r <= 1'b1;
          o_core.performance_monitor_interrupt <= tgt_r;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (i_req.addr == ADDR_GCTL) rdata_nxt = gctl_r;
    if (i_req.addr == ADDR_STATUS) rdata_nxt = 32'(sts_r);
    if (i_req.addr == ADDR_MASK) rdata_nxt = 32'(msk_r);
    if (i_req.addr == ADDR_FIX_LO) rdata_nxt = fix_r[31:0];
    if (i_req.addr == ADDR_FIX_HI) rdata_nxt = 32'(fix_r[FIX_WIDTH-1:32]);
    if (i_req.addr == ADDR_SLICE_EN) rdata_nxt = 32'(slice_en_r);
    for (int k = 0; k < NUM_CTRS; k++) begin
      if (i_req.addr == ADDR_SEL_BASE + 8'(k*4)) rdata_nxt = sel_r[k];
      if (i_req.addr == ADDR_CTR_BASE + 8'(k*CTR_STRIDE)) rdata_nxt = ctr_r[k][31:0];
      if (i_req.addr == ADDR_CTR_BASE + 8'(k*CTR_STRIDE + 4)) begin
        rdata_nxt = 32'(ctr_r[k][GP_WIDTH-1:32]);
      end
    end
  end

  // Read data stands only in the cycle after the strobe; zero otherwise.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 32'h00000000;
    end else begin
      o_rdata <= i_req.rd ? rdata_nxt : 32'h00000000;
    end
  end
endmodule : scec_top

// ### tb/scec_chk_asserts.sv
// Port checker for the shared cache event counter unit.
// Assumes the register map and delivery timing declared in scec_pkg.
`timescale 1ns/100ps
module scec_chk (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Register port.
  input wire scec_pkg::scec_req_t i_req,
  input wire logic [31:0] o_rdata,
  // Core delivery.
  input wire scec_pkg::scec_core_t o_core,
  input wire logic o_irq
);
  import scec_pkg::*;
  logic [3:0] cores_r;
  logic wake_r;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // Shadow of the software-owned delivery fields; freeze never alters them.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cores_r <= 4'h0;
      wake_r <= 1'b0;
    end else if (i_req.wr && i_req.addr == ADDR_GCTL) begin
      cores_r <= i_req.wdata[3:0];
      wake_r <= i_req.wdata[30];
    end
  end
  property p_rd_idle;
    !$past(i_req.rd) |-> o_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_gctl_bits;
    $past(i_req.rd) && $past(i_req.addr) == ADDR_GCTL |-> (o_rdata & ~GCTL_WR_MASK) == 32'h0;
  endproperty
  a_gctl_bits: assert property (p_gctl_bits) else $error("gctl stray bits");
  property p_sel_bits;
    $past(i_req.rd) && $past(i_req.addr[7:6]) == 2'h1 |-> (o_rdata & ~SEL_WR_MASK) == 32'h0;
  endproperty
  a_sel_bits: assert property (p_sel_bits) else $error("selector stray bits");
  property p_ctr_hi;
    $past(i_req.rd) && $past(i_req.addr[7]) && $past(i_req.addr[2]) |-> o_rdata[31:12] == 20'h0;
  endproperty
  a_ctr_hi: assert property (p_ctr_hi) else $error("counter wider than 44");
  property p_fix_hi;
    $past(i_req.rd) && $past(i_req.addr) == ADDR_FIX_HI |-> o_rdata[31:16] == 16'h0;
  endproperty
  a_fix_hi: assert property (p_fix_hi) else $error("tick wider than 48");
  property p_sub;
    ((o_core.performance_monitor_interrupt | o_core.wake) & ~cores_r) == 4'h0;
  endproperty
  a_sub: assert property (p_sub) else $error("delivery to unselected core");
  property p_wake_lead;
    $rose(|o_core.wake) |-> ##3 o_core.performance_monitor_interrupt == $past(o_core.wake, 3);
  endproperty
  a_wake_lead: assert property (p_wake_lead) else $error("no request after wake");
  property p_woken;
    wake_r && |o_core.performance_monitor_interrupt |-> $past(o_core.wake) == o_core.performance_monitor_interrupt;
  endproperty
  a_woken: assert property (p_woken) else $error("request without wake");
  property p_irq_mask;
    i_req.wr && i_req.addr == ADDR_MASK && i_req.wdata == 32'h0 |-> ##2 !o_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt high");
endmodule : scec_chk
bind scec_top scec_chk chk_u (.i_ref_clk, .i_resetn, .i_req, .o_rdata, .o_core, .o_irq);

// ### tb/scec_cores.sv
// Model of the processor cores that take overflow requests and wake requests.
// Assumes the delivery outputs are registered on i_ref_clk.
`timescale 1ns/100ps
module scec_cores (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Delivery from the unit and halt state from the bench.
  input wire scec_pkg::scec_core_t i_core,
  input wire logic [3:0] i_halted,
  // Tallies: one byte of received requests per core, lost ones included.
  output logic [31:0] o_taken,
  output logic [3:0] o_missed
);
  import scec_pkg::*;
  logic [3:0] woke_r;
  // A halted core services a request only after a wake; otherwise it is lost.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_taken <= 32'h0;
      o_missed <= 4'h0;
      woke_r <= 4'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (i_core.wake[c]) woke_r[c] <= 1'b1;
        if (i_core.performance_monitor_interrupt[c]) begin
          o_taken[8*c +: 8] <= o_taken[8*c +: 8] + 8'h01;
          if (i_halted[c] && !woke_r[c]) o_missed[c] <= 1'b1;
          woke_r[c] <= 1'b0;
        end
      end
    end
  end
endmodule : scec_cores

// ### tb/testbench.sv
// Self-checking bench for the shared cache event counter unit.
// Assumes the package register map and the core model beside the unit.
`timescale 1ns/100ps
module testbench;
  import scec_pkg::*;
  localparam int N = 20;
  // Enabled edges around the burst that see a zero event: three before, six after.
  localparam int IDLE_EN = 9;
  logic ref_clk, rst_n, irq, rd_q;
  scec_req_t req;
  scec_core_t core;
  logic [31:0] rdata, taken, seed, tk, ex [10], sw [10];
  logic [NUM_CTRS*EVT_WIDTH-1:0] evt;
  logic [4:0] v [10];
  logic [3:0] halted, missed, cr;
  logic [31:0] eq [$];
  string nq [$];
  int errors, tests_run;
  scec_top dut_u (.i_ref_clk(ref_clk), .i_resetn(rst_n), .i_req(req), .o_rdata(rdata),
    .i_evt(evt), .o_core(core), .o_irq(irq));
  scec_cores cores_u (.i_ref_clk(ref_clk), .i_resetn(rst_n), .i_core(core),
    .i_halted(halted), .o_taken(taken), .o_missed(missed));
  // Free-running 250 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge ref_clk);
    eq.push_back(e);
    nq.push_back(n);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
  endtask : rd
  task idle(input int c);
    @(posedge ref_clk);
    req <= '0;
    repeat (c) @(posedge ref_clk);
  endtask : idle
  task give_verdict;
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Read data stand one cycle only, so they are taken mid-cycle.
  always @(posedge ref_clk) rd_q <= req.rd;
  always @(negedge ref_clk) begin
    if (rd_q === 1'b1) chk(nq.pop_front(), eq.pop_front(), rdata);
  end
  // Watchdog: the run needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    give_verdict();
  end
  // Main sequence: reset values, counting modes, then overflow delivery.
  initial begin
    seed = 32'h15DEAB7C;
    req = '0;
    evt = '0;
    halted = 4'h0;
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ADDR_GCTL, GCTL_RESET, "gctl");
    rd(ADDR_FIX_LO, 32'h0, "tick");
    rd(ADDR_SEL_BASE, SEL_RESET, "sel");
    wr(8'hFC, $random(seed));
    rd(8'hFC, 32'h0, "unmapped");
    wr(ADDR_GCTL, 32'hFFFFFFFF);
    rd(ADDR_GCTL, GCTL_WR_MASK, "gctl_bits");
    wr(ADDR_GCTL, 32'h0);
    wr(ADDR_SEL_BASE + 8'h24, 32'hFFFFFFFF);
    rd(ADDR_SEL_BASE + 8'h24, SEL_WR_MASK, "sel_bits");
    for (int k = 0; k < 10; k++) begin
      v[k] = 5'($random(seed));
      v[k][0] = 1'b1;
    end
    v[7][4] = 1'b0;
    sw = '{32'h00400000, 32'h00C00000, {3'h0, v[2], 24'h400000}, 32'h01440000, 32'h0,
      32'h0040CDAB, 32'h00400000, 32'h1F400000, 32'h00400000, 32'h00C00000};
    // Negated counters also add 31 on every enabled edge that sees a zero event.
    ex = '{N * v[0], N * {27'h0, ~v[1]} + IDLE_EN * 31, N, 1, 0, N * v[5], 0, 0, N * v[8],
      N * {27'h0, ~v[9]} + IDLE_EN * 31};
    wr(ADDR_SLICE_EN, 32'h7);
    for (int k = 0; k < 10; k++) wr(ADDR_SEL_BASE + 8'(4 * k), sw[k]);
    wr(ADDR_GCTL, 32'h20000000);
    idle(2);
    for (int k = 0; k < 10; k++) evt[5*k +: 5] <= v[k];
    repeat (N) @(posedge ref_clk);
    evt <= '0;
    idle(4);
    wr(ADDR_GCTL, 32'h0);
    for (int k = 0; k < 10; k++) begin
      rd(ADDR_CTR_BASE + 8'(8 * k), ex[k], "count");
    end
    // Two enabled edges from the gctl_bits check, then the burst window.
    rd(ADDR_FIX_LO, 32'(2 + N + IDLE_EN), "tick_run");
    cr = 4'($random(seed));
    cr[0] = 1'b1;
    // Pass 0 freezes, unmasked; pass 1 wakes halted cores, masked.
    for (int p = 0; p < 2; p++) begin
      halted <= {4{p[0]}};
      wr(ADDR_MASK, {31'h0, ~p[0]});
      wr(ADDR_CTR_BASE, 32'hFFFFFFFF);
      wr(ADDR_CTR_BASE + 8'h4, 32'h00000FFF);
      wr(ADDR_SEL_BASE, 32'h00500000);
      wr(ADDR_GCTL, (p[0] ? 32'h60000000 : 32'hA0000000) | cr);
      idle(0);
      evt <= 50'h1;
      @(posedge ref_clk);
      evt <= '0;
      idle(8);
      rd(ADDR_GCTL, (p[0] ? 32'h60000000 : 32'h80000000) | cr, "freeze");
      rd(ADDR_STATUS, 32'h1, "status");
      rd(ADDR_CTR_BASE + 8'h4, 32'h0, "wrap");
      idle(2);
      for (int c = 0; c < 4; c++) tk[8*c +: 8] = cr[c] ? 8'(p + 1) : 8'h0;
      chk("irq", {31'h0, ~p[0]}, {31'h0, irq});
      chk("taken", tk, taken);
      chk("missed", 32'h0, {28'h0, missed});
      wr(ADDR_STATUS, 32'h1);
      rd(ADDR_STATUS, 32'h0, "clear");
      idle(2);
      chk("irq_clr", 32'h0, {31'h0, irq});
    end
    idle(4);
    give_verdict();
  end
endmodule : testbench
